// >>> pkg/adccal_pkg.sv
// Notes on behaviour
// - Settle-select field sets wait after each engine tune word change but the last; larger is longer.
// - With tune enable set, tuning starts once synth hold is written zero.
// - Tuning engine steps the tune word until the oscillator is centred.
// - Tune complete reads one after tuning ends, or at once if skipped.
// - Run bit one runs calibration; zero holds it in reset; resets to one.
// - Clearing the run bit also resets digital and link clock dividers.
// - Config bit 3 enables background offset, only with background enabled.
// - Config bit 2 enables foreground offset, needs foreground enabled.
// - Config bit 1 enables background calibration, off after reset.
// - Config bit 0: values always reset; one runs foreground, zero skips it.
// - Tune word is seven bits 6:0, set by the engine, readable by software.
package adccal_pkg;

    localparam logic [7:0] ADDR_TUNE_WORD   = 8'h59;
    localparam logic [7:0] ADDR_SYNTH_HOLD  = 8'h5C;
    localparam logic [7:0] ADDR_TUNE_CTRL   = 8'h5D;
    localparam logic [7:0] ADDR_TUNE_STATUS = 8'h5E;
    localparam logic [7:0] ADDR_CAL_RUN     = 8'h61;
    localparam logic [7:0] ADDR_CAL_CONFIG  = 8'h62;

    localparam logic [7:0] RST_TUNE_WORD    = 8'h00;
    localparam logic [7:0] RST_SYNTH_HOLD   = 8'h00;
    localparam logic [7:0] RST_TUNE_CTRL    = 8'h40;
    localparam logic [7:0] RST_CAL_RUN      = 8'h01;
    localparam logic [7:0] RST_CAL_CONFIG   = 8'h01;

    localparam int TUNE_EN_BIT   = 0;
    localparam int STL_LSB       = 4;
    localparam int STL_MSB       = 6;
    localparam int WORD_MSB      = 6;
    localparam int FG_BIT        = 0;
    localparam int BG_BIT        = 1;
    localparam int FG_OS_BIT     = 2;
    localparam int BG_OS_BIT     = 3;

    // Settle wait is BASE cycles shifted left by the select value
    localparam int SETTLE_BASE_NS = 80;
    localparam int CLK_PERIOD_NS  = 5;
    localparam int SETTLE_BASE_CYC =
        (SETTLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Length of the foreground calibration run
    localparam int FG_RUN_NS  = 1000;
    localparam int FG_RUN_CYC = (FG_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adccal_req_t;

    typedef struct packed {
        logic bg_offset;
        logic fg_offset;
        logic background;
        logic foreground;
    } adccal_mode_t;

endpackage : adccal_pkg

// >>> src/adccal_tuner.sv
module adccal_tuner
    import adccal_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       hold,
    input  wire logic       enable,
    input  wire logic [2:0] settle_sel,
    input  wire logic       above,
    input  wire logic       sw_wr,
    input  wire logic [6:0] sw_word,
    output logic      [6:0] word,
    output logic            done
);

    typedef enum logic [1:0] {T_IDLE, T_SETTLE, T_STEP, T_DONE} adccal_tst_t;

    adccal_tst_t state_r, state_nxt;
    logic [6:0]  word_r, word_nxt;
    logic [6:0]  bit_r, bit_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic        done_r, done_nxt;

    function automatic logic [15:0] settle_len(input logic [2:0] sel);
        settle_len = 16'(SETTLE_BASE_CYC) << sel;
    endfunction : settle_len

    always_comb
    begin
        state_nxt = state_r;
        word_nxt  = word_r;
        bit_nxt   = bit_r;
        cnt_nxt   = cnt_r;
        done_nxt  = done_r;
        if (hold)
        begin
            state_nxt = T_IDLE;
            done_nxt  = 1'b0;
            if (sw_wr)
                word_nxt = sw_word;
        end
        else
        begin
            case (state_r)
                T_IDLE:
                begin
                    if (enable)
                    begin
                        bit_nxt   = 7'h40;
                        word_nxt  = 7'h40;
                        cnt_nxt   = settle_len(settle_sel);
                        done_nxt  = 1'b0;
                        state_nxt = T_SETTLE;
                    end
                    else
                    begin
                        done_nxt  = 1'b1;
                        state_nxt = T_DONE;
                    end
                end
                T_SETTLE:
                begin
                    if (cnt_r <= 16'h0001)
                        state_nxt = T_STEP;
                    else
                        cnt_nxt = cnt_r - 16'h0001;
                end
                T_STEP:
                begin
                    // Binary search on the tune word
                    if (above)
                        word_nxt = (word_r & ~bit_r) | (bit_r >> 1);
                    else
                        word_nxt = word_r | (bit_r >> 1);
                    bit_nxt = bit_r >> 1;
                    cnt_nxt = settle_len(settle_sel);
                    if (bit_r == 7'h01)
                    begin
                        if (above)
                            word_nxt = word_r & ~bit_r;
                        done_nxt  = 1'b1;
                        state_nxt = T_DONE;
                    end
                    else
                        state_nxt = T_SETTLE;
                end
                T_DONE:
                begin
                    if (sw_wr)
                        word_nxt = sw_word;
                end
                default:
                    state_nxt = T_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= T_IDLE;
            word_r  <= RST_TUNE_WORD[6:0];
            bit_r   <= 7'h00;
            cnt_r   <= 16'h0000;
            done_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            word_r  <= word_nxt;
            bit_r   <= bit_nxt;
            cnt_r   <= cnt_nxt;
            done_r  <= done_nxt;
        end
    end

    assign word = word_r;
    assign done = done_r;

endmodule : adccal_tuner

// >>> src/adccal_ctrl.sv
module adccal_ctrl
    import adccal_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       RST_N,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    input  wire logic       OSC_ABOVE,
    input  wire logic       FG_CAL_DONE,
    output logic      [6:0] OSC_TUNE_WORD,
    output logic            SYNTH_HOLD,
    output logic            CAL_RUN,
    output logic            DIV_RESET,
    output logic            FG_START,
    output logic      [3:0] CAL_MODE
);

    adccal_req_t  req;
    logic [7:0]   hold_r, hold_nxt;
    logic [7:0]   tctl_r, tctl_nxt;
    logic [7:0]   run_r, run_nxt;
    logic [7:0]   cfg_r, cfg_nxt;
    logic [7:0]   rdata_r, rdata_nxt;
    logic         fgs_r, fgs_nxt;
    logic         runp_r, runp_nxt;
    logic         divr_r, divr_nxt;
    logic [3:0]   mode_r, mode_nxt;
    logic         above_s1_r, above_s2_r;
    logic [6:0]   word;
    logic         done;
    logic         word_wr;
    adccal_mode_t mode;

    function automatic logic hit(input adccal_req_t r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit

    assign req = '{wr: REG_WR, addr: REG_ADDR, wdata: REG_WDATA};
    assign word_wr = hit(req, ADDR_TUNE_WORD);

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator tuning engine

    adccal_tuner u_tuner (
        .clk        (MCLK),
        .rst_n      (RST_N),
        .hold       (hold_r[0]),
        .enable     (tctl_r[TUNE_EN_BIT]),
        .settle_sel (tctl_r[STL_MSB:STL_LSB]),
        .above      (above_s2_r),
        .sw_wr      (word_wr),
        .sw_word    (REG_WDATA[WORD_MSB:0]),
        .word       (word),
        .done       (done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_comb
    begin
        hold_nxt = hold_r;
        tctl_nxt = tctl_r;
        run_nxt  = run_r;
        cfg_nxt  = cfg_r;
        if (hit(req, ADDR_SYNTH_HOLD))
            hold_nxt = REG_WDATA;
        if (hit(req, ADDR_TUNE_CTRL))
            tctl_nxt = REG_WDATA;
        if (hit(req, ADDR_CAL_RUN))
            run_nxt = REG_WDATA;
        if (hit(req, ADDR_CAL_CONFIG))
            cfg_nxt = REG_WDATA;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Converter calibration control

    always_comb
    begin
        mode.foreground = cfg_r[FG_BIT];
        mode.background = cfg_r[BG_BIT];
        mode.fg_offset  = cfg_r[FG_OS_BIT] & cfg_r[FG_BIT];
        mode.bg_offset  = cfg_r[BG_OS_BIT] & cfg_r[BG_BIT];
        mode_nxt  = mode;
        divr_nxt  = ~run_r[0];
        runp_nxt  = run_r[0];
        // One-cycle foreground start on run rising edge
        fgs_nxt   = run_r[0] & ~runp_r & cfg_r[FG_BIT];
        rdata_nxt = 8'h00;
        if (REG_RD)
        begin
            case (REG_ADDR)
                ADDR_TUNE_WORD:   rdata_nxt = {1'b0, word};
                ADDR_SYNTH_HOLD:  rdata_nxt = hold_r;
                ADDR_TUNE_CTRL:   rdata_nxt = tctl_r;
                ADDR_TUNE_STATUS: rdata_nxt = {7'h00, done};
                ADDR_CAL_RUN:     rdata_nxt = run_r;
                ADDR_CAL_CONFIG:  rdata_nxt = cfg_r;
                default:          rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            hold_r     <= RST_SYNTH_HOLD;
            tctl_r     <= RST_TUNE_CTRL;
            run_r      <= RST_CAL_RUN;
            cfg_r      <= RST_CAL_CONFIG;
            rdata_r    <= 8'h00;
            fgs_r      <= 1'b0;
            // Low so the default run starts foreground after release
            runp_r     <= 1'b0;
            divr_r     <= 1'b0;
            mode_r     <= 4'h0;
            above_s1_r <= 1'b0;
            above_s2_r <= 1'b0;
        end
        else
        begin
            hold_r     <= hold_nxt;
            tctl_r     <= tctl_nxt;
            run_r      <= run_nxt;
            cfg_r      <= cfg_nxt;
            rdata_r    <= rdata_nxt;
            // Foreground start fires once after reset release when enabled
            fgs_r      <= fgs_nxt;
            runp_r     <= runp_nxt;
            divr_r     <= divr_nxt;
            mode_r     <= mode_nxt;
            above_s1_r <= OSC_ABOVE;
            above_s2_r <= above_s1_r;
        end
    end

    assign REG_RDATA     = rdata_r;
    assign OSC_TUNE_WORD = word;
    assign SYNTH_HOLD    = hold_r[0];
    assign CAL_RUN       = run_r[0];
    assign DIV_RESET     = divr_r;
    assign FG_START      = fgs_r;
    assign CAL_MODE      = mode_r;

endmodule : adccal_ctrl

// >>> bench/adccal_assertions.sv
module adccal_chk
    import adccal_pkg::*;
(
    input wire logic       MCLK,
    input wire logic       RST_N,
    input wire logic       REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [6:0] OSC_TUNE_WORD,
    input wire logic       SYNTH_HOLD,
    input wire logic       CAL_RUN,
    input wire logic       DIV_RESET,
    input wire logic       FG_START,
    input wire logic [3:0] CAL_MODE
);
    wire w_run  = REG_WR && REG_ADDR == ADDR_CAL_RUN;
    wire w_cfg  = REG_WR && REG_ADDR == ADDR_CAL_CONFIG;
    wire w_hold = REG_WR && REG_ADDR == ADDR_SYNTH_HOLD;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    ////////////////////////////////////////
    a_run_reset: assert property ($rose(RST_N) |-> CAL_RUN)
        else $error("run bit low after reset");
    a_run_write: assert property (w_run |=> CAL_RUN == $past(REG_WDATA[0]))
        else $error("run bit not taken");
    a_div_follow: assert property (1 |=> DIV_RESET == !$past(CAL_RUN))
        else $error("divider reset wrong");
    a_fg_needs_run: assert property (FG_START |-> CAL_RUN && CAL_MODE[0])
        else $error("start without foreground");
    a_fg_pulse: assert property (FG_START |=> !FG_START)
        else $error("start not a pulse");
    a_bgos_gate: assert property (CAL_MODE[3] |-> CAL_MODE[1])
        else $error("bg offset without bg");
    a_fgos_gate: assert property (CAL_MODE[2] |-> CAL_MODE[0])
        else $error("fg offset without fg");
    a_mode_cfg: assert property (w_cfg |-> ##2
        CAL_MODE[1:0] == $past(REG_WDATA[1:0], 2))
        else $error("mode not from config");
    a_hold_write: assert property (w_hold |=> SYNTH_HOLD == $past(REG_WDATA[0]))
        else $error("hold not taken");
    a_word_held: assert property (SYNTH_HOLD && $past(SYNTH_HOLD) && !REG_WR |=>
        $stable(OSC_TUNE_WORD))
        else $error("word moved in hold");
    c_fg: cover property (FG_START);
    c_div: cover property ($rose(DIV_RESET));
    c_all: cover property (CAL_MODE == 4'hF);
endmodule : adccal_chk

bind adccal_ctrl adccal_chk chk_i (.*);

// >>> bench/tb.sv
module tb
    import adccal_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic       MCLK = 1'h0, RST_N = 1'h0, REG_WR = 1'h0, REG_RD = 1'h0, FG_CAL_DONE = 1'h0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, rd_v;
    logic [6:0] OSC_TUNE_WORD, tgt = 7'h00;
    logic       SYNTH_HOLD, CAL_RUN, DIV_RESET, FG_START;
    logic [3:0] CAL_MODE;
    int         fails = 0, compares = 0;
    logic       OSC_ABOVE = 1'h0;

    adccal_ctrl uut (
        .MCLK          (MCLK),
        .RST_N         (RST_N),
        .REG_WR        (REG_WR),
        .REG_RD        (REG_RD),
        .REG_ADDR      (REG_ADDR),
        .REG_WDATA     (REG_WDATA),
        .REG_RDATA     (REG_RDATA),
        .OSC_ABOVE     (OSC_ABOVE),
        .FG_CAL_DONE   (FG_CAL_DONE),
        .OSC_TUNE_WORD (OSC_TUNE_WORD),
        .SYNTH_HOLD    (SYNTH_HOLD),
        .CAL_RUN       (CAL_RUN),
        .DIV_RESET     (DIV_RESET),
        .FG_START      (FG_START),
        .CAL_MODE      (CAL_MODE)
    );

    // Oscillator comparator, updated just after each rising edge
    always @(posedge MCLK)
    begin
        #1 OSC_ABOVE = OSC_TUNE_WORD > tgt;
    end

    initial
    begin
        forever #2.5 MCLK = ~MCLK;
    end

    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        #1 REG_WR = 1'h1;
        REG_ADDR = a;
        REG_WDATA = d;
        @(posedge MCLK);
        #1 REG_WR = 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge MCLK);
        #1 REG_RD = 1'h1;
        REG_ADDR = a;
        @(posedge MCLK);
        #1 REG_RD = 1'h0;
        rd_v = REG_RDATA;
    endtask : rd

    task automatic report_and_stop;
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////
    task automatic s_reset;
        logic [7:0] ad [7] = '{8'h61, 8'h62, 8'h5D, 8'h59, 8'h5C, 8'h5E, 8'h70};
        logic [7:0] ex [7] = '{8'h01, 8'h01, 8'h40, 8'h00, 8'h00, 8'h01, 8'h00};
        chk(CAL_RUN, 8'h01);
        chk(CAL_MODE, 8'h01);
        chk(FG_START, 8'h01);
        foreach (ad[i])
        begin
            rd(ad[i]);
            chk(rd_v, ex[i]);
        end
    endtask : s_reset

    task automatic fg_try(input logic [7:0] cfg, input logic [7:0] exp);
        logic [7:0] n = 8'h00;
        wr(8'h61, 8'h00);
        wr(8'h62, cfg);
        wr(8'h61, 8'h01);
        repeat (4)
        begin
            n += FG_START;
            @(posedge MCLK);
            #1;
        end
        chk(n, exp);
    endtask : fg_try

    task automatic s_cal;
        logic [7:0] cf [5] = '{8'h0A, 8'h04, 8'h0F, 8'h02, 8'h00};
        logic [3:0] md [5] = '{4'hA, 4'h0, 4'hF, 4'h2, 4'h0};
        wr(8'h61, 8'h00);
        chk(CAL_RUN, 8'h00);
        @(posedge MCLK);
        #1 chk(DIV_RESET, 8'h01);
        foreach (cf[i])
        begin
            wr(8'h62, cf[i]);
            @(posedge MCLK);
            #1 chk(CAL_MODE, md[i]);
            rd(8'h62);
            chk(rd_v, cf[i]);
        end
        fg_try(8'h00, 8'h00);
        fg_try(8'h01, 8'h01);
    endtask : s_cal

    task automatic tune(input logic [7:0] ctrl, input logic [6:0] t);
        int  k;
        int  n;
        int  w;
        time t0;
        w = ctrl[0] ? 7 * (SETTLE_BASE_CYC << ctrl[6:4]) : 0;
        tgt = t;
        wr(8'h5C, 8'h01);
        chk(SYNTH_HOLD, 8'h01);
        wr(8'h5D, ctrl);
        wr(8'h5C, 8'h00);
        chk(SYNTH_HOLD, 8'h00);
        t0 = $time;
        rd(8'h5E);
        if (ctrl[0])
            chk(rd_v, 8'h00);
        for (k = 0; k < 3000 && rd_v !== 8'h01; k++)
            rd(8'h5E);
        if (k == 3000)
        begin
            fails++;
            report_and_stop;
        end
        n = ($time - t0) / 5;
        chk(n >= w && n <= w + 24, 8'h01);
        if (!ctrl[0])
            wr(8'h59, {1'h0, t});
        rd(8'h59);
        chk(rd_v, {1'h0, t});
        chk(OSC_TUNE_WORD, t);
    endtask : tune

    initial
    begin
        repeat (3) @(posedge MCLK);
        #1 RST_N = 1'h1;
        @(posedge MCLK);
        #1;
        s_reset;
        s_cal;
        tune(8'h01, 7'h2B);
        tune(8'h11, 7'h7F);
        tune(8'h41, 7'h00);
        tune(8'h40, 7'h15);
        report_and_stop;
    end
endmodule : tb
